// ### verilog/ths_consts.svh
// constants of the temperature-high and event time stamp block
// assumes inclusion by bare name from the design modules
`ifndef THS_CONSTS_SVH
`define THS_CONSTS_SVH

// ****************************************************
// register byte offsets, capture group codes and high register count on the apb window
// ****************************************************
`define THS_OFF_CTRL 8'h00
`define THS_OFF_STAT 8'h04
`define THS_OFF_THR 8'h08
`define THS_OFF_SEC 8'h0c
`define THS_HI_GRP 3'h2
`define THS_EV_GRP 3'h3
`define THS_HI_REGS 3'h7

// ****************************************************
// control and status bit positions
// ****************************************************
`define THS_B_EVSYNC 4
`define THS_B_EVCLR 8
`define THS_B_HICLR 9
`define THS_B_LOF 0
`define THS_B_HIF 1
`define THS_B_EVF 2

// ****************************************************
// reset values and last bcd hundredths value
// ****************************************************
`define THS_CTRL_RST 9'h000
`define THS_THR_RST 8'h00
`define THS_STAMP_RST 8'h00
`define THS_HUND_LAST 8'h99

// ****************************************************
// timing
// ****************************************************
`define THS_CLK_PERIOD_NS 20
`define THS_HUND_PERIOD_NS 10000000
`define THS_HUND_CYCLES (`THS_HUND_PERIOD_NS / `THS_CLK_PERIOD_NS)

`endif

// ### verilog/ths_pkg.sv
// types of the temperature-high and event time stamp block
// assumes ths_consts.svh on the include path
package ths_pkg;

   // calendar snapshot, bcd bytes, year in the top byte
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] sec;
   } ths_cal_s;

   // full event stamp with hundredths
   typedef struct packed {
      logic [7:0] hund;
      ths_cal_s cal;
   } ths_stamp_s;

   // control register fields, stop in bit 0
   typedef struct packed {
      logic evClr;
      logic evEdge;
      logic evIe;
      logic hiIe;
      logic evSync;
      logic event_overwrite_sel;
      logic hiOw;
      logic hiEn;
      logic stop;
   } ths_ctrl_s;

   // inputs from the temperature sensor logic
   typedef struct packed {
      logic [11:0] temp;
      logic lowEvent;
   } ths_sens_s;

   // start-up sequence for the event pin check
   typedef enum logic [3:0] {
      POR_W1 = 4'b0001,
      POR_W2 = 4'b0010,
      POR_CHK = 4'b0100,
      POR_DONE = 4'b1000
   } ths_por_e;

endpackage

// ### verilog/ths_sync.sv
// two flip-flop synchroniser for one asynchronous level
// assumes the input is a pin outside the clk_sys domain
module ths_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // level in and synchronised level out
   input wire logic din,
   output logic dout
);
   logic meta_ff;

   // first stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule

// ### verilog/ths_prescale.sv
// hundredths counter and one second tick
// assumes stop and restart come from logic on clk_sys
`include "ths_consts.svh"

module ths_prescale #(
   parameter int unsigned CYCLES = 500000
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic stop,
   input wire logic restart,
   // time base
   output logic [7:0] hund,
   output logic secTick
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cyc_ff;
   logic hundStep;

   // a halted or restarted chain gives no step
   assign hundStep = (cyc_ff == LAST) && !stop && !restart;

   // cycle divider down to 100 hz
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cyc_ff <= '0;
      end else if (stop || restart || cyc_ff == LAST) begin
         cyc_ff <= '0;
      end else begin
         cyc_ff <= cyc_ff + 1'b1;
      end
   end

   // bcd hundredths, cleared by stop and resync
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hund <= 8'h00;
      end else if (stop || restart) begin
         hund <= 8'h00;
      end else if (hundStep) begin
         if (hund == `THS_HUND_LAST) begin
            hund <= 8'h00;
         end else if (hund[3:0] == 4'h9) begin
            hund <= {hund[7:4] + 4'h1, 4'h0};
         end else begin
            hund <= {hund[7:4], hund[3:0] + 4'h1};
         end
      end
   end

   // one pulse per wrap, never on a restart
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         secTick <= 1'b0;
      end else begin
         secTick <= hundStep && (hund == `THS_HUND_LAST);
      end
   end
endmodule

// ### verilog/ths_stamp_top.sv
// temperature-high and external event time stamp block, apb slave
// assumes calendar and sensor logic on clk_sys; event pin asynchronous
//
// Operation
// - high stamping only while high enable set
// - each second compare temperature byte against threshold
// - overwrite off: keep first high event only
// - overwrite on: every high event replaces stamp
// - high count increments on every high event
// - high clear zeroes stamps, count, flag
// - reset clears all high capture registers
// - stop halts tick, so no comparisons
// - first high capture needs all registers zero
// - any status write clears high, low flags
// - high event sets flag; irq if enabled
// - host reads of captures defer their update
// - resynchronising never emits an extra tick
// - seconds write or synced event clears hundredths
// - every external event captures the time
// - overwrite off: keep first external event only
// - overwrite on replaces; count always increments
// - each event clear write zeroes eight registers
// - reset clears event captures when pin high
// - event first decision uses zero count only
// - synced event: capture, clear hundredths, drop sync
// - external event sets flag; irq if enabled
//
// The register addresses and the APB register port were left to the implementer.
`include "ths_consts.svh"

module ths_stamp_top #(
   parameter int unsigned HUND_CYCLES = `THS_HUND_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external event pin
   input wire logic evPin,
   // sensor and calendar
   input wire ths_pkg::ths_sens_s sens,
   input wire ths_pkg::ths_cal_s calNow,
   output logic secTick,
   output logic secWrStb,
   output logic [7:0] secWrData,
   // interrupt request, active high
   output logic intReq
);
   import ths_pkg::*;

   // ****************************************************
   // declarations
   // ****************************************************
   ths_ctrl_s ctrl_ff;
   ths_por_e por_ff;
   ths_cal_s hiStamp_ff;
   ths_cal_s hiSnap_ff;
   ths_stamp_s evStamp_ff;
   ths_stamp_s evSnap_ff;
   logic [7:0] thr_ff;
   logic [7:0] hiCnt_ff;
   logic [7:0] evCnt_ff;
   logic [7:0] hund;
   logic [31:0] prdata_ff;
   logic [31:0] rdData;
   logic [55:0] hiVec;
   logic [63:0] evVec;
   logic pready_ff, pslverr_ff, secWrStb_ff, intReq_ff;
   logic [7:0] secWrData_ff;
   logic hiFlag_ff, loFlag_ff, evFlag_ff;
   logic hiPend_ff, evPend_ff, evPrev_ff;
   logic setup, wrAcc, aligned, rdHit, wrHit;
   logic wrCtrl, wrStat, wrThr, wrSec;
   logic hiClrPulse, evClrPulse, evClrAll, porClr;
   logic hiRdBlk, evRdBlk, hiDet, evDet, evIn;
   logic hiApply, evApply, hiFirst, restart;

   // ****************************************************
   // time base and pin synchroniser
   // ****************************************************
   ths_prescale #(
      .CYCLES(HUND_CYCLES)
   ) u_presc (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .stop(ctrl_ff.stop),
      .restart(restart),
      .hund(hund),
      .secTick(secTick)
   );

   ths_sync u_evsync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .din(evPin),
      .dout(evIn)
   );

   // ****************************************************
   // apb decode
   // ****************************************************
   // setup phase, access edge and word alignment
   assign setup = psel && !penable;
   assign wrAcc = psel && penable && pready_ff && pwrite;
   assign aligned = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'b00);
   assign wrCtrl = wrAcc && aligned && paddr[7:0] == `THS_OFF_CTRL;
   assign wrStat = wrAcc && aligned && paddr[7:0] == `THS_OFF_STAT;
   assign wrThr = wrAcc && aligned && paddr[7:0] == `THS_OFF_THR;
   assign wrSec = wrAcc && aligned && paddr[7:0] == `THS_OFF_SEC;
   assign wrHit = aligned && (paddr[7:0] == `THS_OFF_CTRL || paddr[7:0] == `THS_OFF_STAT
                  || paddr[7:0] == `THS_OFF_THR || paddr[7:0] == `THS_OFF_SEC);
   assign hiClrPulse = wrCtrl && pwdata[`THS_B_HICLR];
   assign evClrPulse = wrCtrl && pwdata[`THS_B_EVCLR];

   // host reads of a capture group hold that group
   assign hiRdBlk = psel && !pwrite && aligned && paddr[7:5] == `THS_HI_GRP;
   assign evRdBlk = psel && !pwrite && aligned && paddr[7:5] == `THS_EV_GRP;

   // capture groups as byte vectors, count in byte 0
   assign hiVec = {hiStamp_ff, hiCnt_ff};
   assign evVec = {evStamp_ff.cal, evStamp_ff.hund, evCnt_ff};

   // read mux
   always_comb begin
      rdData = 32'h0000_0000;
      rdHit = aligned;
      if (aligned && paddr[7:5] == `THS_HI_GRP) begin
         if (paddr[4:2] < `THS_HI_REGS) begin
            rdData[7:0] = hiVec[{paddr[4:2], 3'b000} +: 8];
         end else begin
            rdHit = 1'b0;
         end
      end else if (aligned && paddr[7:5] == `THS_EV_GRP) begin
         rdData[7:0] = evVec[{paddr[4:2], 3'b000} +: 8];
      end else begin
         unique case (paddr[7:0])
            `THS_OFF_CTRL: rdData[8:0] = ctrl_ff; // high clear reads 0
            `THS_OFF_STAT: rdData[2:0] = {evFlag_ff, hiFlag_ff, loFlag_ff};
            `THS_OFF_THR: rdData[7:0] = thr_ff;
            `THS_OFF_SEC: rdData[7:0] = calNow.sec;
            default: rdHit = 1'b0;
         endcase
      end
   end

   // zero-wait answer: ready in the first access cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup && (pwrite ? !wrHit : !rdHit);
         if (setup && !pwrite) begin
            prdata_ff <= rdData;
         end
      end
   end

   // ****************************************************
   // control, threshold and seconds write
   // ****************************************************
   // control fields; a written sync enable beats the auto clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= `THS_CTRL_RST;
      end else if (wrCtrl) begin
         ctrl_ff <= pwdata[8:0];
      end else if (evDet && ctrl_ff.evSync) begin
         ctrl_ff.evSync <= 1'b0;
      end
   end

   // threshold register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         thr_ff <= `THS_THR_RST;
      end else if (wrThr) begin
         thr_ff <= pwdata[7:0];
      end
   end

   // seconds write handed to the calendar
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         secWrStb_ff <= 1'b0;
         secWrData_ff <= 8'h00;
      end else begin
         secWrStb_ff <= wrSec;
         if (wrSec) begin
            secWrData_ff <= pwdata[7:0];
         end
      end
   end

   // resync: seconds write or event with sync enabled
   assign restart = wrSec || (evDet && ctrl_ff.evSync);

   // ****************************************************
   // high temperature channel
   // ****************************************************
   // compare once per tick while enabled
   assign hiDet = secTick && ctrl_ff.hiEn && (sens.temp[11:4] > thr_ff);
   assign hiApply = hiPend_ff && !hiRdBlk && !hiClrPulse;
   assign hiFirst = (hiCnt_ff == 8'h00) && (hiStamp_ff == '0);

   // snapshot at detection, held while a read blocks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hiPend_ff <= 1'b0;
         hiSnap_ff <= '0;
      end else if (hiDet) begin
         hiPend_ff <= 1'b1;
         hiSnap_ff <= calNow;
      end else if (hiApply || hiClrPulse) begin
         hiPend_ff <= 1'b0;
      end
   end

   // high capture registers and count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hiCnt_ff <= `THS_STAMP_RST;
         hiStamp_ff <= '0;
      end else if (hiClrPulse) begin
         hiCnt_ff <= `THS_STAMP_RST;
         hiStamp_ff <= '0;
      end else if (hiApply) begin
         hiCnt_ff <= hiCnt_ff + 8'h01;
         if (ctrl_ff.hiOw || hiFirst) begin
            hiStamp_ff <= hiSnap_ff;
         end
      end
   end

   // ****************************************************
   // external event channel
   // ****************************************************
   // start-up: look at the pin once it is synchronised
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         por_ff <= POR_W1;
      end else begin
         unique case (por_ff)
            POR_W1: por_ff <= POR_W2;
            POR_W2: por_ff <= POR_CHK;
            POR_CHK: por_ff <= POR_DONE;
            POR_DONE: por_ff <= POR_DONE;
            default: por_ff <= POR_W1;
         endcase
      end
   end

   assign porClr = (por_ff == POR_CHK) && evIn;
   assign evClrAll = evClrPulse || porClr;

   // edge detect on the synchronised pin, chosen polarity
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         evPrev_ff <= 1'b0;
      end else begin
         evPrev_ff <= evIn;
      end
   end

   assign evDet = (por_ff == POR_DONE)
                  && (ctrl_ff.evEdge ? (evIn && !evPrev_ff) : (!evIn && evPrev_ff));
   assign evApply = evPend_ff && !evRdBlk && !evClrAll;

   // snapshot before the hundredths clear; a tick cycle reads as 99
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         evPend_ff <= 1'b0;
      end else if (evDet) begin
         evPend_ff <= 1'b1;
      end else if (evApply || evClrAll) begin
         evPend_ff <= 1'b0;
      end
   end

   // event snapshot data, no reset needed
   always_ff @(posedge clk_sys) begin
      if (evDet) begin
         evSnap_ff.hund <= secTick ? `THS_HUND_LAST : hund;
         evSnap_ff.cal <= calNow;
      end
   end

   // event capture registers keep contents over reset unless the start-up check sees the pin high
   always_ff @(posedge clk_sys) begin
      if (evClrAll) begin
         evCnt_ff <= `THS_STAMP_RST;
         evStamp_ff <= '0;
      end else if (evApply) begin
         evCnt_ff <= evCnt_ff + 8'h01;
         if (ctrl_ff.event_overwrite_sel || evCnt_ff == 8'h00) begin
            evStamp_ff <= evSnap_ff;
         end
      end
   end

   // ****************************************************
   // flags and interrupt
   // ****************************************************
   // a new event wins over any clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hiFlag_ff <= 1'b0;
         loFlag_ff <= 1'b0;
         evFlag_ff <= 1'b0;
      end else begin
         if (hiDet) begin
            hiFlag_ff <= 1'b1;
         end else if (wrStat || hiClrPulse) begin
            hiFlag_ff <= 1'b0;
         end
         if (sens.lowEvent) begin
            loFlag_ff <= 1'b1;
         end else if (wrStat) begin
            loFlag_ff <= 1'b0;
         end
         if (evDet) begin
            evFlag_ff <= 1'b1;
         end else if (wrStat && !pwdata[`THS_B_EVF]) begin
            evFlag_ff <= 1'b0;
         end
      end
   end

   // interrupt from enabled flags
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         intReq_ff <= 1'b0;
      end else begin
         intReq_ff <= (hiFlag_ff && ctrl_ff.hiIe) || (evFlag_ff && ctrl_ff.evIe);
      end
   end

   // outputs straight from flip-flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign secWrStb = secWrStb_ff;
   assign secWrData = secWrData_ff;
   assign intReq = intReq_ff;

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   hi_disabled_a: assert property (
      (secTick && !ctrl_ff.hiEn && !hiPend_ff) |=> !hiPend_ff)
      else $error("high capture pending while disabled");

   hi_compare_a: assert property (
      (secTick && ctrl_ff.hiEn && sens.temp[11:4] > thr_ff && !hiClrPulse && !wrStat)
      |=> hiFlag_ff && hiPend_ff)
      else $error("high compare did not raise flag");

   hi_first_a: assert property (
      (hiApply && !ctrl_ff.hiOw && hiCnt_ff != 8'h00) |=> $stable(hiStamp_ff))
      else $error("first-event high stamp overwritten");

   hi_over_a: assert property (
      (hiApply && ctrl_ff.hiOw) |=> hiStamp_ff == $past(hiSnap_ff))
      else $error("high stamp not overwritten");

   hi_count_a: assert property (
      hiApply |=> hiCnt_ff == $past(hiCnt_ff) + 8'h01)
      else $error("high count not incremented");

   hi_clear_a: assert property (
      hiClrPulse |=> hiCnt_ff == 8'h00 && hiStamp_ff == '0 && (!hiFlag_ff || $past(hiDet)))
      else $error("high clear incomplete");

   stop_tick_a: assert property (
      ctrl_ff.stop |=> !secTick)
      else $error("tick while stopped");

   stat_clear_a: assert property (
      (wrStat && !hiDet && !sens.lowEvent) |=> !hiFlag_ff && !loFlag_ff)
      else $error("status write left a flag set");

   irq_high_a: assert property (
      hiDet && ctrl_ff.hiIe && !wrCtrl |=> ##1 intReq_ff)
      else $error("high event gave no interrupt");

   rd_block_a: assert property (
      (evRdBlk && !evClrAll) |=> $stable(evCnt_ff) && $stable(evStamp_ff))
      else $error("event capture changed during read");

   sync_seq_a: assert property (
      (evDet && ctrl_ff.evSync && !wrCtrl)
      |=> !ctrl_ff.evSync && hund == 8'h00
          && evSnap_ff.hund == ($past(secTick) ? `THS_HUND_LAST : $past(hund)))
      else $error("synced event order wrong");

   ev_count_a: assert property (
      evApply |=> evCnt_ff == $past(evCnt_ff) + 8'h01)
      else $error("event count not incremented");

   ev_first_a: assert property (
      (evApply && !ctrl_ff.event_overwrite_sel && evCnt_ff == 8'h00) |=> evStamp_ff == $past(evSnap_ff))
      else $error("first event not stamped at zero count");

   irq_event_a: assert property (
      evDet && ctrl_ff.evIe && !wrCtrl |=> ##1 intReq_ff)
      else $error("external event gave no interrupt");

   hi_capture_c: cover property (hiApply && hiFirst);
   ev_sync_c: cover property (evDet && ctrl_ff.evSync);
   ev_deferred_c: cover property (evPend_ff && evRdBlk ##1 evApply);
   ev_wrap_c: cover property (evApply && evCnt_ff == 8'hff);
endmodule

// ### testbench/ths_cal_model.sv
// calendar partner: seconds advance on each tick, load on a seconds write
// assumes secTick and secWrStb are one-cycle pulses on clk_sys
module ths_cal_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // tick and seconds write from the block
   input wire logic secTick,
   input wire logic secWrStb,
   input wire logic [7:0] secWrData,
   // calendar towards the block
   output ths_pkg::ths_cal_s calNow
);
   timeunit 1ns;
   timeprecision 1ps;
   import ths_pkg::*;
   // seconds count binary for simplicity; other fields fixed
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         calNow <= '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h00};
      end else if (secWrStb) begin
         calNow.sec <= secWrData;
      end else if (secTick) begin
         calNow.sec <= calNow.sec + 8'h01;
      end
   end
endmodule

// ### testbench/tb_top.sv
// bench of the high temperature and event stamp block over apb
// assumes ths_pkg compiled first; a calendar model drives calNow
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ths_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic pready, pslverr, er, evPin = 1'b0, secTick, secWrStb, intReq;
   logic [7:0] secWrData, s, expSec;
   ths_sens_s sens = '0;
   ths_cal_s calNow;
   int num_errors = 0, tests_run = 0, seed = 32'hdd98, expCnt, n;
   always #10 clk_sys = ~clk_sys;
   ths_stamp_top #(.HUND_CYCLES(4)) ths_stamp_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .evPin(evPin), .sens(sens),
      .calNow(calNow), .secTick(secTick), .secWrStb(secWrStb), .secWrData(secWrData),
      .intReq(intReq));
   ths_cal_model ths_cal_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .secTick(secTick),
      .secWrStb(secWrStb), .secWrData(secWrData), .calNow(calNow));
   // ****************************************************
   // shared tasks
   // ****************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // no fixed wait count: only the watchdog ends a hung access
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // waits for a second tick, returns the seconds seen at it
   task automatic tick(output logic [7:0] sec);
      while (secTick !== 1'b1) begin
         @(negedge clk_sys);
      end
      sec = calNow.sec;
      repeat (4) @(negedge clk_sys);
   endtask
   // one rising then falling edge on the event pin
   task automatic ev();
      @(posedge clk_sys) evPin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      evPin <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
   // a high event is due when the upper temperature byte is above 40h
   function automatic logic hot(input logic [11:0] t);
      return t[11:4] > 8'h40;
   endfunction
   task automatic final_report();
      $display("errors=%0d comparisons=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      num_errors++;
      final_report();
   end
   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(0, 32'h40, 0); check(rd, 0);
      apb(0, 32'h5c, 0); check(er, 1);
      apb(1, 32'h0c, 32'h15); apb(0, 32'h0c, 0); check(rd, 32'h15);
      apb(1, 32'h08, 32'h40);
      sens.temp <= 12'hfff;
      tick(s); apb(0, 32'h40, 0); check(rd, 0);
      apb(1, 32'h00, 32'h200); apb(1, 32'h00, 32'h26);
      expCnt = 0; expSec = 8'h00;
      // random temperatures against the threshold, overwrite on
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         // boundary first: equal is no event, one above is
         if (i == 0) sens.temp <= 12'h40f;
         else if (i == 1) sens.temp <= 12'h410;
         else sens.temp <= 12'($random(seed));
         tick(s);
         if (hot(sens.temp)) begin
            expCnt++;
            expSec = s;
         end
      end
      apb(0, 32'h40, 0); check(rd, expCnt);
      apb(0, 32'h44, 0); check(rd, expSec);
      sens.temp <= 12'hfff;
      tick(s); apb(0, 32'h04, 0); check(rd[1], 1); check(intReq, 1);
      apb(1, 32'h00, 32'h22); tick(expSec);
      apb(0, 32'h44, 0); check(rd, s);
      apb(0, 32'h40, 0); check(rd, expCnt + 2);
      @(posedge clk_sys) sens.lowEvent <= 1'b1;
      @(posedge clk_sys) sens.lowEvent <= 1'b0;
      apb(1, 32'h04, 32'h4); apb(0, 32'h04, 0); check(rd[1:0], 0); check(intReq, 0);
      apb(1, 32'h00, 32'h222); apb(0, 32'h00, 0); check(rd[9], 0);
      apb(0, 32'h40, 0); check(rd, 0); apb(0, 32'h44, 0); check(rd, 0);
      tick(s); apb(0, 32'h44, 0); check(rd, s);
      // seconds advance once after the last tick, then stop freezes them
      expSec = s + 8'h01;
      // stopped: no tick, no capture
      apb(1, 32'h00, 32'h23); n = 0;
      repeat (900) @(negedge clk_sys) if (secTick === 1'b1) n++;
      check(n, 0); apb(0, 32'h40, 0); check(rd, 1);
      apb(1, 32'h00, 32'h1c1); ev();
      apb(0, 32'h60, 0); check(rd, 1); apb(0, 32'h68, 0); check(rd, expSec);
      apb(0, 32'h04, 0); check(rd[2], 1); check(intReq, 1);
      apb(1, 32'h0c, 32'h27); ev();
      apb(0, 32'h60, 0); check(rd, 2); apb(0, 32'h68, 0); check(rd, expSec);
      apb(1, 32'h00, 32'h1c9); apb(0, 32'h60, 0); check(rd, 0);
      apb(0, 32'h04, 0); check(rd[2], 1);
      ev(); apb(0, 32'h68, 0); check(rd, 32'h27);
      apb(1, 32'h00, 32'h1d9); ev(); apb(0, 32'h00, 0); check(rd[4], 0);
      apb(1, 32'h00, 32'h0c1);
      repeat (255) ev();
      apb(0, 32'h60, 0); check(rd, 0);
      apb(1, 32'h0c, 32'h33); ev();
      apb(0, 32'h68, 0); check(rd, 32'h33);
      // second reset with the pin held high
      @(posedge clk_sys) evPin <= 1'b1;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      apb(0, 32'h60, 0); check(rd, 0); apb(0, 32'h40, 0); check(rd, 0);
      // falling edge mode after reset
      ev();
      apb(0, 32'h60, 0);
      check(rd, 1);
      // seconds write restarts the chain without an extra tick
      apb(1, 32'h0c, 32'h40);
      n = 0;
      repeat (390) @(negedge clk_sys) if (secTick === 1'b1) n++;
      check(n, 0);
      tick(s);
      check(s, 8'h40);
      final_report();
   end
endmodule
